// file: pmim_bank.v
// Interrupt mask bank: suppress registers, event flags, summary and interrupt output
`timescale 1ns/1ns
`include "pmim_defines.vh"

// Contract
// - Misc bit 3 suppresses thermal warning
// - Misc bit 1 suppresses external clock event
// - Misc bit 0 suppresses self-test pass
// - Moderate bit 7 suppresses reset-output mismatch
// - Moderate bit 6 suppresses interrupt-pin mismatch
// - Moderate bit 4 suppresses link error
// - Moderate bit 2 suppresses configuration checksum error
// - Moderate bit 1 suppresses self-test fail
// - State-machine bit 3 suppresses processor power error
// - State-machine bit 2 suppresses controller power error
// - State-machine bit 1 suppresses orderly shutdown
// - State-machine bit 0 suppresses immediate shutdown
// - Comm bit 7 suppresses second-port address error
// - Comm bit 5 suppresses second-port checksum error
// - Comm bit 3 suppresses host-port address error
// - Comm bit 1 suppresses host-port checksum error
// - Comm bit 0 suppresses host-port framing error
// - Masks reset to zero, default loaded from memory
// - Readback mask register at 0x58, reset zero
// - Summary bit clears when its flags clear
module pmim_bank #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output wire [DW-1:0] rd_data_o,
  input wire nvm_load_i,
  input wire [DW-1:0] nvm_misc_default_i,
  input wire [DW-1:0] nvm_mod_default_i,
  input wire [DW-1:0] nvm_fsm_default_i,
  input wire [DW-1:0] nvm_comm_default_i,
  input wire [DW-1:0] nvm_rdbk_default_i,
  input wire thermal_warning_event_i,
  input wire external_clock_event_i,
  input wire self_test_pass_event_i,
  input wire reset_output_mismatch_event_i,
  input wire irq_pin_mismatch_event_i,
  input wire pmic_link_error_event_i,
  input wire config_checksum_error_event_i,
  input wire self_test_fail_event_i,
  input wire processor_power_error_event_i,
  input wire controller_power_error_event_i,
  input wire orderly_shutdown_event_i,
  input wire immediate_shutdown_event_i,
  input wire second_port_address_error_event_i,
  input wire second_port_checksum_error_event_i,
  input wire host_port_address_error_event_i,
  input wire host_port_checksum_error_event_i,
  input wire host_port_framing_error_event_i,
  input wire processor_reset_mismatch_event_i,
  input wire enable_drive_mismatch_event_i,
  output wire [DW-1:0] summary_o,
  output wire irq_o
);

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function hit;
    input [AW-1:0] a;
    input [AW-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wire [DW-1:0] misc_mask;
  wire [DW-1:0] mod_mask;
  wire [DW-1:0] fsm_mask;
  wire [DW-1:0] comm_mask;
  wire [DW-1:0] rdbk_mask;
  wire [DW-1:0] misc_flag;
  wire [DW-1:0] mod_flag;
  wire [DW-1:0] fsm_flag;
  wire [DW-1:0] comm_flag;
  wire [DW-1:0] rdbk_flag;
  reg [DW-1:0] misc_ev;
  reg [DW-1:0] mod_ev;
  reg [DW-1:0] fsm_ev;
  reg [DW-1:0] comm_ev;
  reg [DW-1:0] rdbk_ev;
  reg [DW-1:0] misc_pend;
  reg [DW-1:0] mod_pend;
  reg [DW-1:0] fsm_pend;
  reg [DW-1:0] comm_pend;
  reg [DW-1:0] rdbk_pend;
  reg [DW-1:0] nxt_summary;
  reg [DW-1:0] nxt_rd_data;
  reg [DW-1:0] rd_data_ff;
  reg [DW-1:0] summary_ff;
  reg irq_ff;

  // Named suppress fields
  wire thermal_warning_suppress = misc_mask[`PMIM_MISC_TWARN_BIT];
  wire external_clock_event_suppress = misc_mask[`PMIM_MISC_EXTCLK_BIT];
  wire self_test_pass_suppress = misc_mask[`PMIM_MISC_STPASS_BIT];
  wire reset_output_mismatch_suppress = mod_mask[`PMIM_MOD_RSTOUT_BIT];
  wire irq_pin_mismatch_suppress = mod_mask[`PMIM_MOD_IRQPIN_BIT];
  wire pmic_link_error_suppress = mod_mask[`PMIM_MOD_LINK_BIT];
  wire config_checksum_error_suppress = mod_mask[`PMIM_MOD_CFGCRC_BIT];
  wire self_test_fail_suppress = mod_mask[`PMIM_MOD_STFAIL_BIT];
  wire processor_power_error_suppress = fsm_mask[`PMIM_FSM_PROC_BIT];
  wire controller_power_error_suppress = fsm_mask[`PMIM_FSM_CTRL_BIT];
  wire orderly_shutdown_suppress = fsm_mask[`PMIM_FSM_ORD_BIT];
  wire immediate_shutdown_suppress = fsm_mask[`PMIM_FSM_IMM_BIT];
  wire second_port_address_error_suppress = comm_mask[`PMIM_COMM_P2ADR_BIT];
  wire second_port_checksum_error_suppress = comm_mask[`PMIM_COMM_P2CRC_BIT];
  wire host_port_address_error_suppress = comm_mask[`PMIM_COMM_HADR_BIT];
  wire host_port_checksum_error_suppress = comm_mask[`PMIM_COMM_HCRC_BIT];
  wire host_port_framing_error_suppress = comm_mask[`PMIM_COMM_HFRM_BIT];
  wire processor_reset_mismatch_suppress = rdbk_mask[`PMIM_RDBK_SOCRST_BIT];
  wire enable_drive_mismatch_suppress = rdbk_mask[`PMIM_RDBK_ENDRV_BIT];

  // ----------------------------------------------------------------
  // Suppress registers
  // ----------------------------------------------------------------
  // Miscellaneous group
  pmim_mask_reg #(.WIDTH(DW), .WR_MASK(`PMIM_WM_MISC), .RST_VAL(`PMIM_RST_BYTE)) u_misc_mask (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_i & hit(addr_i, `PMIM_OFF_MISC_MASK)),
    .wr_data_i(wr_data_i),
    .nvm_load_i(nvm_load_i),
    .nvm_data_i(nvm_misc_default_i),
    .q_o(misc_mask)
  );

  // Moderate error group
  pmim_mask_reg #(.WIDTH(DW), .WR_MASK(`PMIM_WM_MOD), .RST_VAL(`PMIM_RST_BYTE)) u_mod_mask (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_i & hit(addr_i, `PMIM_OFF_MOD_MASK)),
    .wr_data_i(wr_data_i),
    .nvm_load_i(nvm_load_i),
    .nvm_data_i(nvm_mod_default_i),
    .q_o(mod_mask)
  );

  // State-machine error group
  pmim_mask_reg #(.WIDTH(DW), .WR_MASK(`PMIM_WM_FSM), .RST_VAL(`PMIM_RST_BYTE)) u_fsm_mask (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_i & hit(addr_i, `PMIM_OFF_FSM_MASK)),
    .wr_data_i(wr_data_i),
    .nvm_load_i(nvm_load_i),
    .nvm_data_i(nvm_fsm_default_i),
    .q_o(fsm_mask)
  );

  // Communication error group
  pmim_mask_reg #(.WIDTH(DW), .WR_MASK(`PMIM_WM_COMM), .RST_VAL(`PMIM_RST_BYTE)) u_comm_mask (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_i & hit(addr_i, `PMIM_OFF_COMM_MASK)),
    .wr_data_i(wr_data_i),
    .nvm_load_i(nvm_load_i),
    .nvm_data_i(nvm_comm_default_i),
    .q_o(comm_mask)
  );

  // Readback error group, reset zero
  pmim_mask_reg #(.WIDTH(DW), .WR_MASK(`PMIM_WM_RDBK), .RST_VAL(`PMIM_RST_BYTE)) u_rdbk_mask (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_i & hit(addr_i, `PMIM_OFF_RDBK_MASK)),
    .wr_data_i(wr_data_i),
    .nvm_load_i(nvm_load_i),
    .nvm_data_i(nvm_rdbk_default_i),
    .q_o(rdbk_mask)
  );

  // ----------------------------------------------------------------
  // Event vectors, placed at the same positions as their suppress bits
  // ----------------------------------------------------------------
  always @* begin
    misc_ev = `PMIM_RST_BYTE;
    mod_ev = `PMIM_RST_BYTE;
    fsm_ev = `PMIM_RST_BYTE;
    comm_ev = `PMIM_RST_BYTE;
    rdbk_ev = `PMIM_RST_BYTE;
    misc_ev[`PMIM_MISC_TWARN_BIT] = thermal_warning_event_i;
    misc_ev[`PMIM_MISC_EXTCLK_BIT] = external_clock_event_i;
    misc_ev[`PMIM_MISC_STPASS_BIT] = self_test_pass_event_i;
    mod_ev[`PMIM_MOD_RSTOUT_BIT] = reset_output_mismatch_event_i;
    mod_ev[`PMIM_MOD_IRQPIN_BIT] = irq_pin_mismatch_event_i;
    mod_ev[`PMIM_MOD_LINK_BIT] = pmic_link_error_event_i;
    mod_ev[`PMIM_MOD_CFGCRC_BIT] = config_checksum_error_event_i;
    mod_ev[`PMIM_MOD_STFAIL_BIT] = self_test_fail_event_i;
    fsm_ev[`PMIM_FSM_PROC_BIT] = processor_power_error_event_i;
    fsm_ev[`PMIM_FSM_CTRL_BIT] = controller_power_error_event_i;
    fsm_ev[`PMIM_FSM_ORD_BIT] = orderly_shutdown_event_i;
    fsm_ev[`PMIM_FSM_IMM_BIT] = immediate_shutdown_event_i;
    comm_ev[`PMIM_COMM_P2ADR_BIT] = second_port_address_error_event_i;
    comm_ev[`PMIM_COMM_P2CRC_BIT] = second_port_checksum_error_event_i;
    comm_ev[`PMIM_COMM_HADR_BIT] = host_port_address_error_event_i;
    comm_ev[`PMIM_COMM_HCRC_BIT] = host_port_checksum_error_event_i;
    comm_ev[`PMIM_COMM_HFRM_BIT] = host_port_framing_error_event_i;
    rdbk_ev[`PMIM_RDBK_SOCRST_BIT] = processor_reset_mismatch_event_i;
    rdbk_ev[`PMIM_RDBK_ENDRV_BIT] = enable_drive_mismatch_event_i;
  end

  // ----------------------------------------------------------------
  // Event flags: latched whatever the suppress bits say
  // ----------------------------------------------------------------
  pmim_flag_reg #(.WIDTH(DW), .IMPL_MASK(`PMIM_WM_MISC), .RST_VAL(`PMIM_RST_BYTE)) u_misc_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(misc_ev),
    .clr_en_i(wr_i & hit(addr_i, `PMIM_OFF_MISC_FLAG)),
    .clr_data_i(wr_data_i),
    .q_o(misc_flag)
  );

  pmim_flag_reg #(.WIDTH(DW), .IMPL_MASK(`PMIM_WM_MOD), .RST_VAL(`PMIM_RST_BYTE)) u_mod_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(mod_ev),
    .clr_en_i(wr_i & hit(addr_i, `PMIM_OFF_MOD_FLAG)),
    .clr_data_i(wr_data_i),
    .q_o(mod_flag)
  );

  pmim_flag_reg #(.WIDTH(DW), .IMPL_MASK(`PMIM_WM_FSM), .RST_VAL(`PMIM_RST_BYTE)) u_fsm_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(fsm_ev),
    .clr_en_i(wr_i & hit(addr_i, `PMIM_OFF_FSM_FLAG)),
    .clr_data_i(wr_data_i),
    .q_o(fsm_flag)
  );

  pmim_flag_reg #(.WIDTH(DW), .IMPL_MASK(`PMIM_WM_COMM), .RST_VAL(`PMIM_RST_BYTE)) u_comm_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(comm_ev),
    .clr_en_i(wr_i & hit(addr_i, `PMIM_OFF_COMM_FLAG)),
    .clr_data_i(wr_data_i),
    .q_o(comm_flag)
  );

  pmim_flag_reg #(.WIDTH(DW), .IMPL_MASK(`PMIM_WM_RDBK), .RST_VAL(`PMIM_RST_BYTE)) u_rdbk_flag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .event_i(rdbk_ev),
    .clr_en_i(wr_i & hit(addr_i, `PMIM_OFF_RDBK_FLAG)),
    .clr_data_i(wr_data_i),
    .q_o(rdbk_flag)
  );

  // ----------------------------------------------------------------
  // Gating: a set suppress bit keeps its flag off the interrupt line
  // ----------------------------------------------------------------
  always @* begin
    misc_pend = `PMIM_RST_BYTE;
    mod_pend = `PMIM_RST_BYTE;
    fsm_pend = `PMIM_RST_BYTE;
    comm_pend = `PMIM_RST_BYTE;
    rdbk_pend = `PMIM_RST_BYTE;
    misc_pend[`PMIM_MISC_TWARN_BIT] = misc_flag[`PMIM_MISC_TWARN_BIT] & ~thermal_warning_suppress;
    misc_pend[`PMIM_MISC_EXTCLK_BIT] = misc_flag[`PMIM_MISC_EXTCLK_BIT] & ~external_clock_event_suppress;
    misc_pend[`PMIM_MISC_STPASS_BIT] = misc_flag[`PMIM_MISC_STPASS_BIT] & ~self_test_pass_suppress;
    mod_pend[`PMIM_MOD_RSTOUT_BIT] = mod_flag[`PMIM_MOD_RSTOUT_BIT] & ~reset_output_mismatch_suppress;
    mod_pend[`PMIM_MOD_IRQPIN_BIT] = mod_flag[`PMIM_MOD_IRQPIN_BIT] & ~irq_pin_mismatch_suppress;
    mod_pend[`PMIM_MOD_LINK_BIT] = mod_flag[`PMIM_MOD_LINK_BIT] & ~pmic_link_error_suppress;
    mod_pend[`PMIM_MOD_CFGCRC_BIT] = mod_flag[`PMIM_MOD_CFGCRC_BIT] & ~config_checksum_error_suppress;
    mod_pend[`PMIM_MOD_STFAIL_BIT] = mod_flag[`PMIM_MOD_STFAIL_BIT] & ~self_test_fail_suppress;
    fsm_pend[`PMIM_FSM_PROC_BIT] = fsm_flag[`PMIM_FSM_PROC_BIT] & ~processor_power_error_suppress;
    fsm_pend[`PMIM_FSM_CTRL_BIT] = fsm_flag[`PMIM_FSM_CTRL_BIT] & ~controller_power_error_suppress;
    fsm_pend[`PMIM_FSM_ORD_BIT] = fsm_flag[`PMIM_FSM_ORD_BIT] & ~orderly_shutdown_suppress;
    fsm_pend[`PMIM_FSM_IMM_BIT] = fsm_flag[`PMIM_FSM_IMM_BIT] & ~immediate_shutdown_suppress;
    comm_pend[`PMIM_COMM_P2ADR_BIT] = comm_flag[`PMIM_COMM_P2ADR_BIT] & ~second_port_address_error_suppress;
    comm_pend[`PMIM_COMM_P2CRC_BIT] = comm_flag[`PMIM_COMM_P2CRC_BIT] & ~second_port_checksum_error_suppress;
    comm_pend[`PMIM_COMM_HADR_BIT] = comm_flag[`PMIM_COMM_HADR_BIT] & ~host_port_address_error_suppress;
    comm_pend[`PMIM_COMM_HCRC_BIT] = comm_flag[`PMIM_COMM_HCRC_BIT] & ~host_port_checksum_error_suppress;
    comm_pend[`PMIM_COMM_HFRM_BIT] = comm_flag[`PMIM_COMM_HFRM_BIT] & ~host_port_framing_error_suppress;
    rdbk_pend[`PMIM_RDBK_SOCRST_BIT] = rdbk_flag[`PMIM_RDBK_SOCRST_BIT] & ~processor_reset_mismatch_suppress;
    rdbk_pend[`PMIM_RDBK_ENDRV_BIT] = rdbk_flag[`PMIM_RDBK_ENDRV_BIT] & ~enable_drive_mismatch_suppress;
  end

  // ----------------------------------------------------------------
  // Summary: one bit per group, falls by itself once its flags are all zero
  // ----------------------------------------------------------------
  always @* begin
    nxt_summary = `PMIM_RST_BYTE;
    nxt_summary[`PMIM_SUM_MISC_BIT] = |misc_flag;
    nxt_summary[`PMIM_SUM_MOD_BIT] = |mod_flag;
    nxt_summary[`PMIM_SUM_FSM_BIT] = |fsm_flag;
    nxt_summary[`PMIM_SUM_COMM_BIT] = |comm_flag;
    nxt_summary[`PMIM_SUM_RDBK_BIT] = |rdbk_flag;
  end

  // ----------------------------------------------------------------
  // Read mux: unmapped addresses and reserved bits read zero
  // ----------------------------------------------------------------
  always @* begin
    nxt_rd_data = `PMIM_RST_BYTE;
    if (rd_i) begin
      if (hit(addr_i, `PMIM_OFF_MISC_MASK)) begin
        nxt_rd_data = misc_mask;
      end else if (hit(addr_i, `PMIM_OFF_MOD_MASK)) begin
        nxt_rd_data = mod_mask;
      end else if (hit(addr_i, `PMIM_OFF_FSM_MASK)) begin
        nxt_rd_data = fsm_mask;
      end else if (hit(addr_i, `PMIM_OFF_COMM_MASK)) begin
        nxt_rd_data = comm_mask;
      end else if (hit(addr_i, `PMIM_OFF_RDBK_MASK)) begin
        nxt_rd_data = rdbk_mask;
      end else if (hit(addr_i, `PMIM_OFF_MISC_FLAG)) begin
        nxt_rd_data = misc_flag;
      end else if (hit(addr_i, `PMIM_OFF_MOD_FLAG)) begin
        nxt_rd_data = mod_flag;
      end else if (hit(addr_i, `PMIM_OFF_FSM_FLAG)) begin
        nxt_rd_data = fsm_flag;
      end else if (hit(addr_i, `PMIM_OFF_COMM_FLAG)) begin
        nxt_rd_data = comm_flag;
      end else if (hit(addr_i, `PMIM_OFF_RDBK_FLAG)) begin
        nxt_rd_data = rdbk_flag;
      end else if (hit(addr_i, `PMIM_OFF_SUMMARY)) begin
        nxt_rd_data = summary_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_ff <= `PMIM_RST_BYTE;
      summary_ff <= `PMIM_RST_BYTE;
      irq_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      summary_ff <= nxt_summary;
      irq_ff <= |{misc_pend, mod_pend, fsm_pend, comm_pend, rdbk_pend};
    end
  end

  assign rd_data_o = rd_data_ff;
  assign summary_o = summary_ff;
  assign irq_o = irq_ff;
endmodule // pmim_bank

// file: pmim_defines.vh
// Offsets, field positions, reset values and write masks of the interrupt mask bank
`ifndef PMIM_DEFINES_VH
`define PMIM_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PMIM_OFF_MISC_MASK 8'h53
`define PMIM_OFF_MOD_MASK 8'h54
`define PMIM_OFF_FSM_MASK 8'h56
`define PMIM_OFF_COMM_MASK 8'h57
`define PMIM_OFF_RDBK_MASK 8'h58
`define PMIM_OFF_MISC_FLAG 8'h61
`define PMIM_OFF_MOD_FLAG 8'h62
`define PMIM_OFF_FSM_FLAG 8'h63
`define PMIM_OFF_COMM_FLAG 8'h64
`define PMIM_OFF_RDBK_FLAG 8'h65
`define PMIM_OFF_SUMMARY 8'h66

// ----------------------------------------------------------------
// Reset values and implemented-bit masks (reserved bits are zero)
// ----------------------------------------------------------------
`define PMIM_RST_BYTE 8'h00
`define PMIM_WM_MISC 8'h0b
`define PMIM_WM_MOD 8'hd6
`define PMIM_WM_FSM 8'h0f
`define PMIM_WM_COMM 8'hab
`define PMIM_WM_RDBK 8'h09

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMIM_MISC_TWARN_BIT 3
`define PMIM_MISC_EXTCLK_BIT 1
`define PMIM_MISC_STPASS_BIT 0
`define PMIM_MOD_RSTOUT_BIT 7
`define PMIM_MOD_IRQPIN_BIT 6
`define PMIM_MOD_LINK_BIT 4
`define PMIM_MOD_CFGCRC_BIT 2
`define PMIM_MOD_STFAIL_BIT 1
`define PMIM_FSM_PROC_BIT 3
`define PMIM_FSM_CTRL_BIT 2
`define PMIM_FSM_ORD_BIT 1
`define PMIM_FSM_IMM_BIT 0
`define PMIM_COMM_P2ADR_BIT 7
`define PMIM_COMM_P2CRC_BIT 5
`define PMIM_COMM_HADR_BIT 3
`define PMIM_COMM_HCRC_BIT 1
`define PMIM_COMM_HFRM_BIT 0
`define PMIM_RDBK_SOCRST_BIT 3
`define PMIM_RDBK_ENDRV_BIT 0
`define PMIM_SUM_MISC_BIT 0
`define PMIM_SUM_MOD_BIT 1
`define PMIM_SUM_FSM_BIT 2
`define PMIM_SUM_COMM_BIT 3
`define PMIM_SUM_RDBK_BIT 4

`endif

// file: pmim_mask_reg.v
// One byte-wide suppress register with a loadable power-up default
`timescale 1ns/1ns
module pmim_mask_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] WR_MASK = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire wr_en_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire nvm_load_i,
  input wire [WIDTH-1:0] nvm_data_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] mask_ff;
  reg [WIDTH-1:0] nxt_mask;

  // ----------------------------------------------------------------
  // Next value: software write beats the default load
  // ----------------------------------------------------------------
  always @* begin
    nxt_mask = mask_ff;
    if (wr_en_i) begin
      nxt_mask = wr_data_i & WR_MASK;
    end else if (nvm_load_i) begin
      nxt_mask = nvm_data_i & WR_MASK;
    end
  end

  // Storage; reserved bits never leave zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= RST_VAL;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  assign q_o = mask_ff;
endmodule // pmim_mask_reg

// file: pmim_flag_reg.v
// Sticky event flags, cleared by writing ones; a new event beats the clear
`timescale 1ns/1ns
module pmim_flag_reg #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] IMPL_MASK = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] event_i,
  input wire clr_en_i,
  input wire [WIDTH-1:0] clr_data_i,
  output wire [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] flag_ff;
  reg [WIDTH-1:0] nxt_flag;

  // ----------------------------------------------------------------
  // Next value: clear selected bits, then OR in fresh events
  // ----------------------------------------------------------------
  always @* begin
    nxt_flag = flag_ff;
    if (clr_en_i) begin
      nxt_flag = nxt_flag & ~clr_data_i;
    end
    nxt_flag = (nxt_flag | event_i) & IMPL_MASK;
  end

  // Storage
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= RST_VAL;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign q_o = flag_ff;
endmodule // pmim_flag_reg

// file: pmim_bank_chk.sv
// Assertion checker for the interrupt mask bank
`timescale 1ns/1ns
module pmim_bank_chk #(parameter AW = 8, parameter DW = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [DW-1:0] rd_data_o,
  input wire logic nvm_load_i,
  input wire logic thermal_warning_event_i,
  input wire logic [DW-1:0] summary_o,
  input wire logic irq_o
);
  // Shadow of the misc suppress register; unknown once defaults load
  logic [7:0] misc_sh_ff;
  logic sh_ok_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      misc_sh_ff <= 8'h00;
      sh_ok_ff <= 1'b1;
    end else if (wr_i && addr_i == 8'h53) begin
      misc_sh_ff <= wr_data_i & 8'h0b;
      sh_ok_ff <= 1'b1;
    end else if (nvm_load_i) begin
      sh_ok_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Thermal event while its suppress bit is known clear and not changing
  sequence s_thermal_live;
    thermal_warning_event_i && sh_ok_ff && !misc_sh_ff[3] && !nvm_load_i && !(wr_i && addr_i == 8'h53);
  endsequence
  sequence s_summary_fall;
    $fell(summary_o[0]);
  endsequence

  a_read_idle_zero: assert property (!rd_i |=> rd_data_o == 8'h00) else $error("read data not zero when idle");
  a_unmapped_read: assert property (rd_i && addr_i == 8'h55 |=> rd_data_o == 8'h00) else $error("unmapped read");
  a_misc_readback: assert property (rd_i && addr_i == 8'h53 && sh_ok_ff |=> rd_data_o == $past(misc_sh_ff))
    else $error("misc suppress readback wrong");
  a_thermal_irq: assert property (s_thermal_live |-> ##2 irq_o) else $error("thermal event gave no irq");
  a_thermal_summary: assert property (thermal_warning_event_i |-> ##2 summary_o[0])
    else $error("thermal event not in summary");
  a_summary_top_zero: assert property (summary_o[7:5] == 3'b000) else $error("summary upper bits set");
  a_reset_quiet: assert property ($past(rst_i) |-> !irq_o && summary_o == 8'h00)
    else $error("outputs not quiet after reset");
  a_irq_has_source: assert property (irq_o |-> summary_o != 8'h00) else $error("irq without a flag");
  a_summary_clear: assert property (s_summary_fall |-> $past(wr_i, 2) && $past(addr_i, 2) == 8'h61)
    else $error("misc summary fell without a clear");
endmodule // pmim_bank_chk

bind pmim_bank pmim_bank_chk #(.AW(AW), .DW(DW)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .nvm_load_i(nvm_load_i),
  .thermal_warning_event_i(thermal_warning_event_i), .summary_o(summary_o), .irq_o(irq_o));

// file: testbench.sv
// Self-checking testbench for the interrupt mask bank
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic nvm_load_i = 1'b0;
  logic [7:0] nvm_dflt = 8'h00;
  logic [18:0] ev = 19'h0_0000;
  logic [7:0] rd_data_o;
  logic [7:0] summary_o;
  logic irq_o;
  logic [7:0] got;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] ma [5] = '{8'h53, 8'h54, 8'h56, 8'h57, 8'h58};
  logic [7:0] wm [5] = '{8'h0b, 8'hd6, 8'h0f, 8'hab, 8'h09};
  int bt [19] = '{3, 1, 0, 7, 6, 4, 2, 1, 3, 2, 1, 0, 7, 5, 3, 1, 0, 3, 0};
  int gp [19] = '{0, 0, 0, 1, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 3, 3, 3, 4, 4};

  always #5 clk_i = ~clk_i;

  pmim_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .nvm_load_i(nvm_load_i), .nvm_misc_default_i(nvm_dflt), .nvm_mod_default_i(nvm_dflt),
    .nvm_fsm_default_i(nvm_dflt), .nvm_comm_default_i(nvm_dflt), .nvm_rdbk_default_i(nvm_dflt),
    .thermal_warning_event_i(ev[0]), .external_clock_event_i(ev[1]), .self_test_pass_event_i(ev[2]),
    .reset_output_mismatch_event_i(ev[3]), .irq_pin_mismatch_event_i(ev[4]), .pmic_link_error_event_i(ev[5]),
    .config_checksum_error_event_i(ev[6]), .self_test_fail_event_i(ev[7]), .processor_power_error_event_i(ev[8]),
    .controller_power_error_event_i(ev[9]), .orderly_shutdown_event_i(ev[10]), .immediate_shutdown_event_i(ev[11]),
    .second_port_address_error_event_i(ev[12]), .second_port_checksum_error_event_i(ev[13]),
    .host_port_address_error_event_i(ev[14]), .host_port_checksum_error_event_i(ev[15]),
    .host_port_framing_error_event_i(ev[16]), .processor_reset_mismatch_event_i(ev[17]),
    .enable_drive_mismatch_event_i(ev[18]), .summary_o(summary_o), .irq_o(irq_o));

  // Compare one byte result
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One-cycle bus write and read
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rd_data_o;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    #100000;
    error_cnt++;
    results;
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(summary_o, 8'h00);
    for (int g = 0; g < 5; g++) begin
      rd(ma[g]);
      chk(got, 8'h00);
      wr(ma[g], 8'hff);
      rd(ma[g]);
      chk(got, wm[g]);
    end
    wr(8'h55, 8'hff);
    rd(8'h55);
    chk(got, 8'h00);
    $display("test reset_and_reserved done");
    @(posedge clk_i);
    nvm_load_i <= 1'b1;
    nvm_dflt <= 8'h55;
    @(posedge clk_i);
    nvm_load_i <= 1'b0;
    for (int g = 0; g < 5; g++) begin
      rd(ma[g]);
      chk(got, 8'h55 & wm[g]);
      wr(ma[g], 8'h00);
    end
    $display("test default_load done");
    for (int i = 0; i < 19; i++) begin
      pulse(i);
      wait_n(1);
      chk({7'h00, irq_o}, 8'h01);
      chk(summary_o, 8'h01 << gp[i]);
      rd(8'(8'h61 + gp[i]));
      chk(got, 8'h01 << bt[i]);
      wr(ma[gp[i]], 8'h01 << bt[i]);
      wait_n(1);
      chk({7'h00, irq_o}, 8'h00);
      chk(summary_o, 8'h01 << gp[i]);
      wr(8'(8'h61 + gp[i]), 8'h01 << bt[i]);
      wait_n(1);
      chk(summary_o, 8'h00);
      wr(ma[gp[i]], 8'h00);
    end
    $display("test per_source done");
    // A clear in the same cycle as a new event leaves the flag set
    pulse(0);
    @(posedge clk_i);
    ev[0] <= 1'b1;
    wr_i <= 1'b1;
    addr_i <= 8'h61;
    wr_data_i <= 8'h08;
    @(posedge clk_i);
    ev[0] <= 1'b0;
    wr_i <= 1'b0;
    rd(8'h61);
    chk(got, 8'h08);
    wr(8'h53, 8'h0b);
    // An event that arrives while suppressed still latches its flag
    pulse(1);
    wait_n(1);
    chk({7'h00, irq_o}, 8'h00);
    rd(8'h61);
    chk(got, 8'h0a);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h53);
    chk(got, 8'h00);
    chk(summary_o, 8'h00);
    $display("test clear_race_and_reset done");
    results;
  end
endmodule // testbench
